// ===== hw/cdv_decode.sv
// Page-one opcode decoder with branch evaluation and vector selection.
// Assumes a classic Wishbone master on clk_i; one clock, no interrupt output.
module cdv_decode
    import cdv_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic [7:0]  opcode, next_opcode;
    logic [7:0]  flags, next_flags;
    logic [15:0] operand, next_operand;
    logic [15:0] pc, next_pc;
    logic [15:0] index_x, next_index_x;
    logic [15:0] index_y, next_index_y;
    logic [15:0] stack_ptr, next_stack_ptr;
    logic [15:0] accum_d, next_accum_d;
    logic [NUM_REQ-1:0]  request, next_request;
    logic [NUM_PERI-1:0] enable, next_enable;
    logic [31:0] rdata, next_rdata;
    logic        ack, next_ack;

    // Decode results
    logic [5:0]  cycles;
    cdv_mode_e   mode;
    logic        is_branch;
    logic        taken;
    logic        prefix;
    logic        illegal;
    logic [15:0] target;
    logic [15:0] vector;
    logic        vec_valid;
    logic [7:0]  mem_byte;
    logic [7:0]  mask_byte;
    logic [15:0] ea;

    assign mem_byte  = operand[15:8];
    assign mask_byte = operand[7:0];

    // -------------------------------------------------------------------
    // Cycle count and addressing mode
    // -------------------------------------------------------------------
    // counts are E cycles
    always_comb begin
        cycles  = 6'd0;
        mode    = CDV_MODE_NONE;
        prefix  = 1'b0;
        illegal = 1'b0;
        casez (opcode)
            8'h01, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
            8'h0F, 8'h10, 8'h11, 8'h16, 8'h17, 8'h1B: begin
                cycles = 6'd2;
                mode   = CDV_MODE_INH;
            end
            8'h02, 8'h03: begin
                cycles = 6'd41;
                mode   = CDV_MODE_INH;
            end
            8'h04, 8'h05, 8'h08, 8'h09: begin
                cycles = 6'd3;
                mode   = CDV_MODE_INH;
            end
            8'h12, 8'h13, 8'h14, 8'h15: begin
                cycles = 6'd6;
                mode   = CDV_MODE_DIR;
            end
            8'h1C, 8'h1D, 8'h1E, 8'h1F: begin
                cycles = 6'd7;
                mode   = CDV_MODE_IDX;
            end
            OP_PAGE2, OP_PAGE3, OP_PAGE4: begin
                prefix = 1'b1;
            end
            8'h19: begin
                cycles = 6'd2;
                mode   = CDV_MODE_INH;
            end
            8'h2?: begin
                cycles = 6'd3;
                mode   = CDV_MODE_REL;
            end
            8'h30, 8'h31, 8'h34, 8'h35, 8'h3A: begin
                cycles = 6'd3;
                mode   = CDV_MODE_INH;
            end
            8'h32, 8'h33: begin
                cycles = 6'd4;
                mode   = CDV_MODE_INH;
            end
            8'h36, 8'h37: begin
                cycles = 6'd3;
                mode   = CDV_MODE_INH;
            end
            8'h38, 8'h39: begin
                cycles = 6'd5;
                mode   = CDV_MODE_INH;
            end
            8'h3B: begin
                cycles = 6'd12;
                mode   = CDV_MODE_INH;
            end
            8'h3C: begin
                cycles = 6'd4;
                mode   = CDV_MODE_INH;
            end
            8'h3D: begin
                cycles = 6'd10;
                mode   = CDV_MODE_INH;
            end
            8'h3E, OP_SW_TRAP: begin
                cycles = 6'd14;
                mode   = CDV_MODE_INH;
            end
            8'h40, 8'h43, 8'h44, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A,
            8'h4C, 8'h4D, 8'h4F: begin
                cycles = 6'd2;
                mode   = CDV_MODE_INH;
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // Branch condition
    // -------------------------------------------------------------------
    always_comb begin
        is_branch = 1'b1;
        taken     = 1'b0;
        case (opcode)
            OP_BR_ALWAYS: taken = 1'b1;
            OP_BR_NEVER:  taken = 1'b0;
            8'h22: taken = ~(flags[FLAG_C] | flags[FLAG_Z]);
            8'h23: taken = flags[FLAG_C] | flags[FLAG_Z];
            8'h24: taken = ~flags[FLAG_C];
            8'h25: taken = flags[FLAG_C];
            8'h26: taken = ~flags[FLAG_Z];
            8'h27: taken = flags[FLAG_Z];
            8'h28: taken = ~flags[FLAG_V];
            8'h29: taken = flags[FLAG_V];
            8'h2A: taken = ~flags[FLAG_N];
            8'h2B: taken = flags[FLAG_N];
            8'h2C: taken = ~(flags[FLAG_N] ^ flags[FLAG_V]);
            8'h2D: taken = flags[FLAG_N] ^ flags[FLAG_V];
            8'h2E: taken = ~(flags[FLAG_Z] | (flags[FLAG_N] ^ flags[FLAG_V]));
            8'h2F: taken = flags[FLAG_Z] | (flags[FLAG_N] ^ flags[FLAG_V]);
            OP_BRANCH_BITS_CLEAR_DIR, OP_BRANCH_BITS_CLEAR_IDX: taken = ((mem_byte & mask_byte) == 8'h00);
            OP_BRANCH_BITS_SET_DIR, OP_BRANCH_BITS_SET_IDX: taken = ((~mem_byte & mask_byte) == 8'h00);
            default: is_branch = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------
    // Effective address and branch target
    // -------------------------------------------------------------------
    always_comb begin
        case (mode)
            CDV_MODE_DIR: ea = {8'h00, operand[15:8]};
            CDV_MODE_IDX: ea = index_x + {8'h00, operand[15:8]};
            default:      ea = operand;
        endcase
        target = pc + {{8{operand[7]}}, operand[7:0]};
    end

    // -------------------------------------------------------------------
    // Vector selection, highest priority first
    // -------------------------------------------------------------------
    always_comb begin
        vector    = RST_WORD;
        vec_valid = 1'b1;
        if (request[REQ_RESET]) begin
            vector = VEC_RESET;
        end else if (request[REQ_CLKMON]) begin
            vector = VEC_CLKMON;
        end else if (request[REQ_WDOG]) begin
            vector = VEC_WDOG;
        end else if (request[REQ_ILLEGAL] || illegal) begin
            vector = VEC_ILLEGAL;
        end else if (request[REQ_SWI] || opcode == OP_SW_TRAP) begin
            vector = VEC_SWI;
        // X gates pin request, I gates external pin
        end else if (request[REQ_XPIN] && !flags[FLAG_X]) begin
            vector = VEC_XPIN;
        end else if (request[REQ_IRQPIN] && !flags[FLAG_I]) begin
            vector = VEC_IRQPIN;
        end else begin
            vec_valid = 1'b0;
            // peripherals need I clear and enable
            for (int k = 0; k < NUM_PERI; k++) begin
                if (!vec_valid && !flags[FLAG_I] && request[REQ_PERI_LO + k] && enable[k]) begin
                    vec_valid = 1'b1;
                    vector    = VEC_PERI_HI - 16'(2 * k);
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Wishbone slave, one wait state, ack drops after one cycle
    // -------------------------------------------------------------------
    logic req_hit;
    assign req_hit = wb_cyc_i & wb_stb_i & ~ack;

    always_comb begin
        next_opcode    = opcode;
        next_flags     = flags;
        next_operand   = operand;
        next_pc        = pc;
        next_index_x   = index_x;
        next_index_y   = index_y;
        next_stack_ptr = stack_ptr;
        next_accum_d   = accum_d;
        next_request   = request;
        next_enable    = enable;
        next_rdata     = 32'h0000_0000;
        next_ack       = req_hit;
        if (req_hit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_OPCODE:  next_opcode = wb_dat_i[7:0];
                ADDR_FLAGS:   next_flags  = wb_dat_i[7:0];
                ADDR_OPERAND: next_operand = {wb_sel_i[1] ? wb_dat_i[15:8] : operand[15:8], wb_dat_i[7:0]};
                ADDR_PC:      next_pc = {wb_sel_i[1] ? wb_dat_i[15:8] : pc[15:8], wb_dat_i[7:0]};
                ADDR_INDEX:   next_index_x = {wb_sel_i[1] ? wb_dat_i[15:8] : index_x[15:8], wb_dat_i[7:0]};
                ADDR_REQUEST: next_request = wb_dat_i[NUM_REQ-1:0];
                ADDR_ENABLE:  next_enable  = wb_dat_i[NUM_PERI-1:0];
                ADDR_ACCUM:   next_accum_d = {wb_sel_i[1] ? wb_dat_i[15:8] : accum_d[15:8], wb_dat_i[7:0]};
                ADDR_REGS2:   begin
                    next_index_y   = {wb_sel_i[1] ? wb_dat_i[15:8] : index_y[15:8], wb_dat_i[7:0]};
                    next_stack_ptr = {wb_sel_i[3] ? wb_dat_i[31:24] : stack_ptr[15:8],
                                      wb_sel_i[2] ? wb_dat_i[23:16] : stack_ptr[7:0]};
                end
                default: ;
            endcase
        end
        if (req_hit && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_OPCODE:  next_rdata = {24'h00_0000, opcode};
                ADDR_FLAGS:   next_rdata = {24'h00_0000, flags};
                ADDR_OPERAND: next_rdata = {16'h0000, operand};
                ADDR_PC:      next_rdata = {16'h0000, pc};
                ADDR_INDEX:   next_rdata = {16'h0000, index_x};
                ADDR_REQUEST: next_rdata = {11'h000, request};
                ADDR_ENABLE:  next_rdata = {18'h0_0000, enable};
                ADDR_DECODE:  next_rdata = {16'h0000, 2'b00, cycles, 4'h0,
                                            illegal, prefix, is_branch & taken, ~illegal & ~prefix};
                ADDR_TARGET:  next_rdata = {ea, (is_branch & taken) ? target : pc};
                ADDR_VECTOR:  next_rdata = {15'h0000, vec_valid, vector};
                ADDR_ACCUM:   next_rdata = {13'h0000, mode, accum_d};
                ADDR_REGS2:   next_rdata = {stack_ptr, index_y};
                default:      next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opcode    <= 8'h01;
            flags     <= RST_FLAGS;
            operand   <= RST_WORD;
            pc        <= RST_WORD;
            index_x   <= RST_WORD;
            index_y   <= RST_WORD;
            stack_ptr <= RST_WORD;
            accum_d   <= RST_WORD;
            request   <= '0;
            enable    <= '0;
            rdata     <= 32'h0000_0000;
            ack       <= 1'b0;
        end else begin
            opcode    <= next_opcode;
            flags     <= next_flags;
            operand   <= next_operand;
            pc        <= next_pc;
            index_x   <= next_index_x;
            index_y   <= next_index_y;
            stack_ptr <= next_stack_ptr;
            accum_d   <= next_accum_d;
            request   <= next_request;
            enable    <= next_enable;
            rdata     <= next_rdata;
            ack       <= next_ack;
        end
    end

    assign wb_dat_o = rdata;
    assign wb_ack_o = ack;
endmodule

// ===== hw/cdv_pkg.sv
// Package for the opcode decode and vector selection block.
// Assumes a single 100 MHz clock domain and a classic Wishbone master.
package cdv_pkg;
    // -------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_OPCODE   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS    = 8'h04;
    localparam logic [7:0] ADDR_OPERAND  = 8'h08;
    localparam logic [7:0] ADDR_PC       = 8'h0C;
    localparam logic [7:0] ADDR_INDEX    = 8'h10;
    localparam logic [7:0] ADDR_REQUEST  = 8'h14;
    localparam logic [7:0] ADDR_ENABLE   = 8'h18;
    localparam logic [7:0] ADDR_DECODE   = 8'h1C;
    localparam logic [7:0] ADDR_TARGET   = 8'h20;
    localparam logic [7:0] ADDR_VECTOR   = 8'h24;
    localparam logic [7:0] ADDR_ACCUM    = 8'h28;
    localparam logic [7:0] ADDR_REGS2    = 8'h2C;
    // -------------------------------------------------------------------
    // Flag bit positions in the condition code register
    // -------------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_I = 4;
    localparam int FLAG_X = 6;
    // -------------------------------------------------------------------
    // Request bit positions
    // -------------------------------------------------------------------
    localparam int REQ_RESET   = 0;
    localparam int REQ_CLKMON  = 1;
    localparam int REQ_WDOG    = 2;
    localparam int REQ_SWI     = 3;
    localparam int REQ_ILLEGAL = 4;
    localparam int REQ_XPIN    = 5;
    localparam int REQ_IRQPIN  = 6;
    localparam int REQ_PERI_LO = 7;
    localparam int NUM_PERI    = 14;
    localparam int NUM_REQ     = 21;
    // -------------------------------------------------------------------
    // Vector addresses
    // -------------------------------------------------------------------
    localparam logic [15:0] VEC_RESET   = 16'hFFFE;
    localparam logic [15:0] VEC_CLKMON  = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG    = 16'hFFFA;
    localparam logic [15:0] VEC_ILLEGAL = 16'hFFF8;
    localparam logic [15:0] VEC_SWI     = 16'hFFF6;
    localparam logic [15:0] VEC_XPIN    = 16'hFFF4;
    localparam logic [15:0] VEC_IRQPIN  = 16'hFFF2;
    localparam logic [15:0] VEC_PERI_HI = 16'hFFF0;
    localparam logic [15:0] VEC_SERIAL  = 16'hFFD6;
    localparam logic [15:0] VEC_RSV_LO  = 16'hFFC0;
    localparam logic [15:0] VEC_RSV_HI  = 16'hFFD5;
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0]  RST_FLAGS   = 8'h50;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    // -------------------------------------------------------------------
    // Opcodes with dedicated handling
    // -------------------------------------------------------------------
    localparam logic [7:0] OP_BR_ALWAYS = 8'h20;
    localparam logic [7:0] OP_BR_NEVER  = 8'h21;
    localparam logic [7:0] OP_PAGE2     = 8'h18;
    localparam logic [7:0] OP_PAGE3     = 8'h1A;
    localparam logic [7:0] OP_PAGE4     = 8'hCD;
    localparam logic [7:0] OP_SW_TRAP   = 8'h3F;
    localparam logic [7:0] OP_BRANCH_BITS_SET_DIR = 8'h12;
    localparam logic [7:0] OP_BRANCH_BITS_CLEAR_DIR = 8'h13;
    localparam logic [7:0] OP_BRANCH_BITS_SET_IDX = 8'h1E;
    localparam logic [7:0] OP_BRANCH_BITS_CLEAR_IDX = 8'h1F;
    // -------------------------------------------------------------------
    // Timing: one E cycle is four crystal periods
    // -------------------------------------------------------------------
    localparam int E_DIV = 4;
    // Decode status fields
    localparam int DEC_VALID = 0;
    localparam int DEC_TAKEN = 1;
    localparam int DEC_PREFIX = 2;
    localparam int DEC_ILLEGAL = 3;
    localparam int DEC_CYC_LO = 8;
    typedef enum logic [2:0] {
        CDV_MODE_INH, CDV_MODE_IMM, CDV_MODE_DIR, CDV_MODE_EXT,
        CDV_MODE_IDX, CDV_MODE_REL, CDV_MODE_NONE
    } cdv_mode_e;
endpackage

// ===== verif/cdv_chk.sv
// Bus-side checker for the opcode decoder: judges decode and vector reads.
// Assumes writes carry all byte lanes; shadows opcode and operand itself.
module cdv_chk
    import cdv_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  op;
    logic [7:0]  next_op;
    logic [15:0] opnd;
    logic [15:0] next_opnd;
    logic        wr;
    logic        rd_dec;
    logic        rd_vec;
    logic [5:0]  cyc;
    // Shadows follow acked writes only, one cycle after the registers take them on the request
    assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign rd_dec = wb_cyc_i & wb_stb_i & !wb_we_i & wb_ack_o & (wb_adr_i == ADDR_DECODE);
    assign rd_vec = wb_cyc_i & wb_stb_i & !wb_we_i & wb_ack_o & (wb_adr_i == ADDR_VECTOR);
    assign cyc    = wb_dat_o[13:8];
    always_comb begin
        next_op   = op;
        next_opnd = opnd;
        if (wr && wb_adr_i == ADDR_OPCODE) next_op = wb_dat_i[7:0];
        if (wr && wb_adr_i == ADDR_OPERAND) next_opnd = wb_dat_i[15:0];
    end
    always_ff @(posedge clk_i) begin
        op   <= rst_i ? 8'h01 : next_op;
        opnd <= rst_i ? 16'h0000 : next_opnd;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_answer: assert property (p_answer) else $error("ack not a single pulse after request");
    property p_br_always;
        rd_dec && op == OP_BR_ALWAYS |-> wb_dat_o[DEC_TAKEN] && cyc == 6'h03;
    endproperty
    a_br_always: assert property (p_br_always) else $error("always branch wrong");
    property p_br_cycles;
        rd_dec && op[7:4] == 4'h2 |-> cyc == 6'h03 && !wb_dat_o[DEC_ILLEGAL];
    endproperty
    a_br_cycles: assert property (p_br_cycles) else $error("branch cycle count wrong");
    property p_bits_clear;
        rd_dec && op == OP_BRANCH_BITS_CLEAR_DIR |-> wb_dat_o[DEC_TAKEN] == ((opnd[15:8] & opnd[7:0]) == 8'h00);
    endproperty
    a_bits_clear: assert property (p_bits_clear) else $error("bits clear branch wrong");
    property p_bits_set;
        rd_dec && op == OP_BRANCH_BITS_SET_DIR |-> wb_dat_o[DEC_TAKEN] == ((~opnd[15:8] & opnd[7:0]) == 8'h00);
    endproperty
    a_bits_set: assert property (p_bits_set) else $error("bits set branch wrong");
    property p_prefix;
        rd_dec && (op == OP_PAGE2 || op == OP_PAGE3) |-> wb_dat_o[DEC_PREFIX] && !wb_dat_o[DEC_ILLEGAL];
    endproperty
    a_prefix: assert property (p_prefix) else $error("page prefix not flagged");
    property p_divide;
        rd_dec && (op == 8'h02 || op == 8'h03) |-> cyc == 6'h29;
    endproperty
    a_divide: assert property (p_divide) else $error("divide cycle count wrong");
    property p_vec_rsv;
        rd_vec && wb_dat_o[16] |-> !(wb_dat_o[15:0] inside {[VEC_RSV_LO:VEC_RSV_HI]});
    endproperty
    a_vec_rsv: assert property (p_vec_rsv) else $error("reserved vector selected");
endmodule

bind cdv_decode cdv_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ===== verif/cdv_mem_model.sv
// Far-side memory model: one byte for every 16-bit address.
// Assumes combinational reads; content is a fixed hash of the address.
module cdv_mem_model (
    input  wire logic [15:0] addr_i,
    output logic      [7:0]  data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Rotated high byte keeps neighbouring pages distinct
    assign data_o = addr_i[7:0] ^ {addr_i[12:8], addr_i[15:13]} ^ 8'hA5;
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the opcode decoder over its Wishbone port.
// Assumes the memory model supplies operand bytes; one 100 MHz clock.
module testbench
    import cdv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CYC_TAB [30] = '{16'h1206, 16'h1306, 16'h1E07, 16'h1F07, 16'h1406, 16'h1506,
        16'h1C07, 16'h1D07, 16'h0229, 16'h0329, 16'h0403, 16'h0503, 16'h3D0A, 16'h3E0E, 16'h3F0E, 16'h3B0C,
        16'h3C04, 16'h3204, 16'h3304, 16'h3603, 16'h3703, 16'h3805, 16'h3905, 16'h3003, 16'h3103, 16'h3403,
        16'h3503, 16'h1902, 16'h4002, 16'h4F02};
    localparam logic [7:0] BB_OPS [4] = '{8'h12, 8'h13, 8'h1E, 8'h1F};
    localparam logic [7:0] SP_OPS [5] = '{8'h18, 8'h1A, 8'h00, 8'h41, 8'h3F};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dato;
    logic        ack;
    logic [15:0] maddr = 16'h0000;
    logic [7:0]  mbyte;
    logic [31:0] seed = 32'h0000_B14B;
    logic [31:0] rd, r, s;
    logic [7:0]  op, f;
    logic [20:0] q;
    logic [16:0] v;
    logic        tk;
    int          err_total = 0;
    int          tests_run = 0;
    int          ticks = 0;
    always #5 clk = ~clk;
    cdv_decode DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack));
    cdv_mem_model mem (.addr_i(maddr), .data_o(mbyte));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Odd opcodes test the condition, even ones its inverse
    function automatic logic br_exp(input logic [7:0] o, input logic [7:0] c);
        logic p;
        case (o[3:1])
            3'h0: p = 1'b0;
            3'h1: p = c[FLAG_C] | c[FLAG_Z];
            3'h2: p = c[FLAG_C];
            3'h3: p = c[FLAG_Z];
            3'h4: p = c[FLAG_V];
            3'h5: p = c[FLAG_N];
            3'h6: p = c[FLAG_N] ^ c[FLAG_V];
            default: p = c[FLAG_Z] | (c[FLAG_N] ^ c[FLAG_V]);
        endcase
        return o[0] ? p : !p;
    endfunction
    function automatic logic [16:0] vec_exp(input logic [20:0] w, input logic [13:0] e, input logic [7:0] c);
        if (w[REQ_RESET]) return {1'b1, VEC_RESET};
        if (w[REQ_CLKMON]) return {1'b1, VEC_CLKMON};
        if (w[REQ_WDOG]) return {1'b1, VEC_WDOG};
        if (w[REQ_ILLEGAL]) return {1'b1, VEC_ILLEGAL};
        if (w[REQ_SWI]) return {1'b1, VEC_SWI};
        if (w[REQ_XPIN] && !c[FLAG_X]) return {1'b1, VEC_XPIN};
        if (w[REQ_IRQPIN] && !c[FLAG_I]) return {1'b1, VEC_IRQPIN};
        for (int k = 0; k < NUM_PERI; k++)
            if (w[REQ_PERI_LO + k] && e[k] && !c[FLAG_I]) return {1'b1, VEC_PERI_HI - 16'(2 * k)};
        return 17'h0_0000;
    endfunction
    // Classic cycle: held until ack is sampled, released at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 12000) begin
            err_total++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdr(ADDR_FLAGS);
        chk("flags reset", {24'h00_0000, RST_FLAGS}, rd);
        rdr(ADDR_OPCODE);
        chk("opcode reset", 32'h0000_0001, rd);
        rdr(8'h40);
        chk("unmapped read", 32'h0000_0000, rd);
        $display("reset test done");
        // Opcode is still the reset one here, so the mode field reads as inherent (0)
        r = rnd();
        s = rnd();
        wr(ADDR_ACCUM, r);
        wr(ADDR_REGS2, s);
        rdr(ADDR_ACCUM);
        chk("double accum", {16'h0000, r[15:0]}, rd);
        rdr(ADDR_REGS2);
        chk("index and stack", s, rd);
        $display("register file test done");
        for (int i = 0; i < 64; i++) begin
            op = {4'h2, 4'(i)};
            f = 8'(rnd());
            r = rnd();
            wr(ADDR_FLAGS, {24'h00_0000, f});
            wr(ADDR_OPERAND, {16'h0000, r[15:0]});
            wr(ADDR_PC, {16'h0000, r[31:16]});
            wr(ADDR_OPCODE, {24'h00_0000, op});
            tk = br_exp(op, f);
            rdr(ADDR_DECODE);
            chk("branch decode", {18'h0_0000, 6'h03, 6'h00, tk, 1'b1}, rd);
            rdr(ADDR_TARGET);
            chk("target", {16'h0000, tk ? r[31:16] + {{8{r[7]}}, r[7:0]} : r[31:16]}, rd & 32'h0000_FFFF);
        end
        $display("branch test done");
        foreach (CYC_TAB[j]) begin
            wr(ADDR_OPCODE, {24'h00_0000, CYC_TAB[j][15:8]});
            rdr(ADDR_DECODE);
            s = {25'h000_0000, CYC_TAB[j][5:0], 1'b0};
            r = {25'h000_0000, rd[13:8], rd[DEC_ILLEGAL]};
            chk("cycles", s, r);
        end
        for (int i = 0; i < 64; i++) begin
            op = BB_OPS[i % 4];
            r = rnd();
            maddr = op[3] ? r[31:16] + {8'h00, r[15:8]} : {8'h00, r[15:8]};
            wr(ADDR_INDEX, {16'h0000, r[31:16]});
            wr(ADDR_OPERAND, {16'h0000, mbyte, r[7:0] & r[23:16]});
            wr(ADDR_OPCODE, {24'h00_0000, op});
            tk = op[0] ? (mbyte & r[7:0] & r[23:16]) == 8'h00 : (~mbyte & r[7:0] & r[23:16]) == 8'h00;
            rdr(ADDR_DECODE);
            chk("bit branch", {31'h0000_0000, tk}, {31'h0000_0000, rd[DEC_TAKEN]});
            // Address byte sits in the upper operand byte; indexed adds it unsigned
            s = {op[3] ? r[31:16] + {8'h00, mbyte} : {8'h00, mbyte}, 16'h0000};
            rdr(ADDR_TARGET);
            chk("eff addr", s, rd & 32'hFFFF_0000);
        end
        $display("cycle and bit test done");
        wr(ADDR_REQUEST, 32'h0000_0000);
        foreach (SP_OPS[j]) begin
            wr(ADDR_OPCODE, {24'h00_0000, SP_OPS[j]});
            rdr(ADDR_DECODE);
            chk("prefix illegal", {30'h0000_0000, j == 2 || j == 3, j < 2}, {30'h0000_0000, rd[3:2]});
            rdr(ADDR_VECTOR);
            if (j > 1) chk("trap", {15'h0000, 1'b1, j == 4 ? VEC_SWI : VEC_ILLEGAL}, rd);
        end
        $display("prefix and trap test done");
        wr(ADDR_OPCODE, 32'h0000_0001);
        for (int i = 0; i < 84; i++) begin
            r = rnd();
            s = rnd();
            q = (21'h00_0001 << (i % 21)) | (r[20:0] & s[20:0] & r[31:11]);
            f = {1'b0, r[30], 1'b0, r[29], 4'h0};
            wr(ADDR_FLAGS, {24'h00_0000, f});
            wr(ADDR_ENABLE, {18'h0_0000, s[31:18]});
            wr(ADDR_REQUEST, {11'h000, q});
            v = vec_exp(q, s[31:18], f);
            rdr(ADDR_VECTOR);
            chk("vector", {15'h0000, v}, {15'h0000, rd[16], v[16] ? rd[15:0] : 16'h0000});
        end
        $display("vector test done");
        finish_test();
    end
endmodule
